// ===== dsw_pkg.sv
// dsw_pkg: constants and types for the drive status word logic
// assumes: included first in compile order
package dsw_pkg;
  localparam int DSW_WIDTH = 16;
  // control word bit positions
  localparam int CTL_ON = 0;
  localparam int CTL_COAST_STOP_ABSENT = 1;
  localparam int CTL_QUICK_STOP_ABSENT = 2;
  localparam int CTL_ENABLE = 3;
  localparam int CTL_RUN_TOGGLE = 6;
  localparam int CTL_FAULT_ACK = 7;
  localparam int CTL_REMOTE = 10;
  // status word bit positions
  localparam int ST_RDY_SWON = 0;
  localparam int ST_RDY_OP = 1;
  localparam int ST_OP_EN = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_COAST_STOP_ABSENT = 4;
  localparam int ST_QUICK_STOP_ABSENT = 5;
  localparam int ST_SWON_INHIBIT = 6;
  localparam int ST_WARNING = 7;
  localparam int ST_NO_FOLLOW_ERR = 8;
  localparam int ST_CTRL_REQ = 9;
  localparam int ST_TARGET_REACHED = 10;
  localparam int ST_REF_SET = 11;
  localparam int ST_TARGET_ACK = 12;
  localparam int ST_STANDSTILL = 13;
  localparam int ST_OVERCURRENT = 14;
  localparam int ST_POS_LIMIT = 15;
  localparam logic [15:0] DSW_STATUS_RESET = 16'h0000;
  localparam logic [15:0] DSW_CONTROL_RESET = 16'h0000;

  // ordered drive state, one-hot
  typedef enum logic [5:0] {
    DSW_NOT_READY = 6'h01,
    DSW_RDY_SWON = 6'h02,
    DSW_RDY_OP = 6'h04,
    DSW_OP_EN = 6'h08,
    DSW_FAULT = 6'h10,
    DSW_INHIBIT = 6'h20
  } dsw_state_e;

  // motion, presence and fault events from the drive core
  typedef struct packed {
    logic errorActive;
    logic overcurrent;
    logic presenceStart;
    logic presenceDetect;
    logic markedRequired;
    logic runStart;
    logic runDone;
    logic targetArrive;
    logic moving;
    logic inFollowWindow;
    logic outsideLimits;
  } dsw_event_s;
endpackage

// ===== dsw_edge_detect.sv
// dsw_edge_detect: per-bit falling-edge detector for the control word
// assumes: input already in the ref_clk domain
`timescale 1ns/1ps
module dsw_edge_detect #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  input wire logic clkEn,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] fallPulse,
  output logic [WIDTH-1:0] prevLevel
);
  import dsw_pkg::*;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  always_comb
  begin
    prev_d = clkEn ? din : prev_q;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      prev_q <= '0;
    else
      prev_q <= prev_d;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign fallPulse[i] = clkEn & prev_q[i] & ~din[i];
    end
  endgenerate
  assign prevLevel = prev_q;
endmodule

// ===== dsw_status_word.sv
// dsw_status_word: status word generator of a networked positioning drive
// assumes: control word and events arrive synchronous to ref_clk
`timescale 1ns/1ps
module dsw_status_word (
  // clock, enable and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // cyclic process data
  input wire logic [15:0] controlWord,
  output logic [15:0] driveStatusWord,
  // drive core events
  input wire dsw_pkg::dsw_event_s events,
  output logic moveStart,
  output dsw_pkg::dsw_state_e driveState
);
  import dsw_pkg::*;

  // reset asserts at once and releases through two flops
  logic rstMeta_q;
  logic rstSync_q;
  logic rstN;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstN = rstSync_q;

  // falling edges of the control word, frozen with clkEn
  logic [15:0] ctlFall;
  logic [15:0] ctlPrev;
  dsw_edge_detect #(.WIDTH(DSW_WIDTH)) u_edge (
    .clk(ref_clk),
    .rstN(rstN),
    .clkEn(clkEn),
    .din(controlWord),
    .fallPulse(ctlFall),
    .prevLevel(ctlPrev)
  );

  dsw_state_e state_q;
  dsw_state_e state_d;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic ackFall;
  logic atLeastRdyOp;
  logic belowRdyOp;
  logic startMove;
  logic errAtOp;

  assign ackFall = ctlFall[CTL_FAULT_ACK];
  assign atLeastRdyOp = (state_q == DSW_RDY_OP) || (state_q == DSW_OP_EN);
  assign belowRdyOp = (state_q == DSW_NOT_READY) || (state_q == DSW_RDY_SWON);
  assign startMove = atLeastRdyOp && events.runStart
                     && (controlWord[CTL_RUN_TOGGLE] != status_q[ST_TARGET_ACK]);
  assign errAtOp = atLeastRdyOp && (events.errorActive || events.overcurrent);
  assign moveStart = clkEn && startMove;
  assign driveState = state_q;

  // next drive state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DSW_NOT_READY:
        if (controlWord[CTL_REMOTE])
          state_d = DSW_RDY_SWON;
      DSW_RDY_SWON:
        if (!controlWord[CTL_REMOTE])
          state_d = DSW_NOT_READY;
        else if (controlWord[CTL_ON])
          state_d = DSW_RDY_OP;
      DSW_RDY_OP, DSW_OP_EN:
        if (errAtOp)
          state_d = DSW_FAULT;
        else if (!controlWord[CTL_REMOTE])
          state_d = DSW_NOT_READY;
        else if (!controlWord[CTL_ON])
          state_d = DSW_RDY_SWON;
        else if (state_q == DSW_RDY_OP && controlWord[CTL_ENABLE])
          state_d = DSW_OP_EN;
        else if (state_q == DSW_OP_EN && !controlWord[CTL_ENABLE])
          state_d = DSW_RDY_OP;
      DSW_FAULT:
        if (ackFall)
          state_d = DSW_INHIBIT;
      DSW_INHIBIT:
        if (ctlFall[CTL_ON])
          state_d = controlWord[CTL_REMOTE] ? DSW_RDY_SWON : DSW_NOT_READY;
      default:
        state_d = DSW_NOT_READY;
    endcase
    if (!clkEn)
      state_d = state_q;
  end

  // next status word, one clause per status bit, except one shared clause for bits 4, 5, 9 and 11
  always_comb
  begin
    status_d = status_q;
    status_d[ST_RDY_SWON] = controlWord[CTL_REMOTE];
    if (!controlWord[CTL_ON])
      status_d[ST_RDY_OP] = 1'b0;
    else if (state_q == DSW_RDY_SWON && controlWord[CTL_REMOTE])
      status_d[ST_RDY_OP] = 1'b1;
    if (!controlWord[CTL_ENABLE])
      status_d[ST_OP_EN] = 1'b0;
    else if (state_q == DSW_RDY_OP)
      status_d[ST_OP_EN] = 1'b1;
    if (errAtOp)
      status_d[ST_FAULT] = 1'b1;
    else if (ackFall)
      status_d[ST_FAULT] = 1'b0;
    if (events.presenceDetect || events.markedRequired)
    begin
      status_d[ST_COAST_STOP_ABSENT] = 1'b1;
      status_d[ST_QUICK_STOP_ABSENT] = 1'b1;
      status_d[ST_CTRL_REQ] = 1'b1;
      status_d[ST_REF_SET] = 1'b1;
    end
    else if (events.presenceStart)
    begin
      status_d[ST_COAST_STOP_ABSENT] = 1'b0;
      status_d[ST_QUICK_STOP_ABSENT] = 1'b0;
      status_d[ST_CTRL_REQ] = 1'b0;
      status_d[ST_REF_SET] = 1'b0;
    end
    if (state_q == DSW_FAULT && ackFall)
      status_d[ST_SWON_INHIBIT] = 1'b1;
    else if (ctlFall[CTL_ON])
      status_d[ST_SWON_INHIBIT] = 1'b0;
    if (events.errorActive || events.overcurrent)
      status_d[ST_WARNING] = 1'b1;
    else if (!status_q[ST_FAULT] || (ackFall && !errAtOp))
      status_d[ST_WARNING] = 1'b0;
    if (events.presenceStart)
      status_d[ST_NO_FOLLOW_ERR] = 1'b0;
    else if (events.moving)
      status_d[ST_NO_FOLLOW_ERR] = events.inFollowWindow;
    // target reached, held in fault and inhibit
    if (events.targetArrive)
      status_d[ST_TARGET_REACHED] = 1'b1;
    else if (startMove || belowRdyOp)
      status_d[ST_TARGET_REACHED] = 1'b0;
    if (belowRdyOp)
      status_d[ST_TARGET_ACK] = 1'b0;
    else if (startMove)
      status_d[ST_TARGET_ACK] = controlWord[CTL_RUN_TOGGLE];
    if (events.runDone)
      status_d[ST_STANDSTILL] = 1'b1;
    else if (startMove)
      status_d[ST_STANDSTILL] = 1'b0;
    if (events.overcurrent)
      status_d[ST_OVERCURRENT] = 1'b1;
    else if (ackFall)
      status_d[ST_OVERCURRENT] = 1'b0;
    status_d[ST_POS_LIMIT] = events.outsideLimits;
    if (!clkEn)
      status_d = status_q;
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_q <= DSW_NOT_READY;
      status_q <= DSW_STATUS_RESET;
    end
    else
    begin
      state_q <= state_d;
      status_q <= status_d;
    end
  end

  assign driveStatusWord = status_q;
endmodule

// ===== dsw_status_word_props.sv
// dsw_status_word_props: port-level checks of the status word logic
// assumes: bound to dsw_status_word, all inputs on ref_clk
`timescale 1ns/1ps
module dsw_status_word_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // process data and events
  input wire logic [15:0] controlWord,
  input wire logic [15:0] driveStatusWord,
  input wire dsw_pkg::dsw_event_s events,
  input wire logic moveStart,
  input wire dsw_pkg::dsw_state_e driveState
);
  import dsw_pkg::*;
  logic [15:0] cw;
  logic [15:0] sw;
  logic opUp;
  assign cw = controlWord;
  assign sw = driveStatusWord;
  assign opUp = (driveState == DSW_RDY_OP) || (driveState == DSW_OP_EN);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rdy_swon: assert property (
    clkEn && cw[10] && driveState == DSW_NOT_READY |=> sw[0])
    else $error("ready to switch on not set");
  a_rdy_op: assert property (
    clkEn && cw[10] && cw[0] && driveState == DSW_RDY_SWON |=> sw[1])
    else $error("ready for operation not set");
  a_op_en: assert property (
    clkEn && cw[10] && cw[3] && cw[0] && driveState == DSW_RDY_OP |=> sw[2])
    else $error("operation enabled not set");
  a_fault_set: assert property (
    clkEn && events.errorActive && opUp |=> sw[3] && sw[7])
    else $error("fault or warning not set");
  a_presence_set: assert property (
    clkEn && (events.presenceDetect || events.markedRequired) |=> (sw & 16'h0a30) == 16'h0a30)
    else $error("presence bits not set");
  a_overcur_fault: assert property (clkEn && events.overcurrent && opUp
    |=> sw[14] && driveState == DSW_FAULT) else $error("overcurrent not flagged");
  a_pos_limit: assert property (clkEn |=> sw[15] == $past(events.outsideLimits))
    else $error("position limit mismatch");
  a_move_gate: assert property (
    moveStart |-> clkEn && events.runStart && opUp && cw[6] != sw[12])
    else $error("movement started without toggle");
  a_ack_load: assert property (
    moveStart |=> sw[12] == $past(cw[6]) && !sw[13] && !sw[10])
    else $error("run start bits wrong");
  a_inhibit_set: assert property (
    clkEn && $past(clkEn) && $fell(cw[7]) && driveState == DSW_FAULT |=> sw[6] && !sw[3])
    else $error("acknowledge did not inhibit");
  a_target_hold: assert property (
    clkEn && (driveState == DSW_FAULT || driveState == DSW_INHIBIT) && !events.targetArrive
    |=> $stable(sw[10])) else $error("target reached not held");
  a_follow_win: assert property (
    clkEn && events.moving && !events.presenceStart |=> sw[8] == $past(events.inFollowWindow))
    else $error("following error bit mismatch");
endmodule
bind dsw_status_word dsw_status_word_props chk_u (.ref_clk, .rst_n, .clkEn, .controlWord,
  .driveStatusWord, .events, .moveStart, .driveState);

// ===== dsw_plc_model.sv
// dsw_plc_model: controller side, owns the cyclic control word
// assumes: tasks called from the bench, changes land at falling edges
`timescale 1ns/1ps
module dsw_plc_model (
  // clock
  input wire logic ref_clk,
  // process data
  input wire logic [15:0] statusWord,
  output logic [15:0] controlWord
);
  initial controlWord = 16'h0000;
  task automatic setCw(input logic [15:0] v);
    @(negedge ref_clk) controlWord = v;
  endtask
  task automatic requestRun();
    @(negedge ref_clk) controlWord[6] = ~statusWord[12];
  endtask
  task automatic ackFault();
    @(negedge ref_clk) controlWord[7] = 1'b1;
    @(negedge ref_clk) controlWord[7] = 1'b0;
  endtask
endmodule

// ===== dsw_status_word_tb.sv
// dsw_status_word_tb: self-checking bench for the status word logic
// assumes: controller model and checker compiled before it
`timescale 1ns/1ps
module dsw_status_word_tb;
  import dsw_pkg::*;
  logic ref_clk;
  logic rst_n;
  logic clkEn;
  logic moveStart;
  logic [15:0] controlWord;
  logic [15:0] driveStatusWord;
  dsw_event_s events;
  dsw_state_e driveState;
  int badCount;
  int numChecks;
  int cyc;
  dsw_status_word dut_u (.ref_clk, .rst_n, .clkEn, .controlWord, .driveStatusWord, .events,
    .moveStart, .driveState);
  dsw_plc_model plc_u (.ref_clk, .statusWord(driveStatusWord), .controlWord);
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic rep(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [15:0] m, input logic [15:0] e);
    rep(driveStatusWord & m, e);
  endtask
  task automatic chkMv(input logic e);
    rep({15'h0000, moveStart}, {15'h0000, e});
  endtask
  task automatic chkSt(input dsw_state_e e);
    rep({10'h000, driveState}, {10'h000, e});
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic tally_and_finish();
    if (badCount == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      badCount++;
      tally_and_finish();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    events = '0;
    step(20);
    rst_n = 1'b1;
    step(4);
    events.presenceDetect = 1'b1;
    step(1);
    chk(16'h0a30, 16'h0a30);
    events.presenceDetect = 1'b0;
    events.presenceStart = 1'b1;
    step(1);
    chk(16'h0a30, 16'h0000);
    events.presenceStart = 1'b0;
    clkEn = 1'b0;
    events.outsideLimits = 1'b1;
    events.markedRequired = 1'b1;
    step(1);
    chk(16'h8a30, 16'h0000);
    clkEn = 1'b1;
    step(1);
    chk(16'h8a30, 16'h8a30);
    events.outsideLimits = 1'b0;
    events.markedRequired = 1'b0;
    step(1);
    chk(16'h8000, 16'h0000);
    plc_u.setCw(16'h0400);
    step(1);
    chk(16'h0007, 16'h0001);
    plc_u.setCw(16'h0401);
    step(1);
    chk(16'h0007, 16'h0003);
    plc_u.setCw(16'h0409);
    step(1);
    chk(16'h0007, 16'h0007);
    chkSt(DSW_OP_EN);
    plc_u.requestRun();
    events.runStart = 1'b1;
    events.moving = 1'b1;
    events.inFollowWindow = 1'b1;
    #1;
    chkMv(1'b1);
    step(1);
    events.runStart = 1'b0;
    chk(16'h3400, 16'h1000);
    step(1);
    chk(16'h0100, 16'h0100);
    events.inFollowWindow = 1'b0;
    step(1);
    chk(16'h0100, 16'h0000);
    events.moving = 1'b0;
    events.runDone = 1'b1;
    events.targetArrive = 1'b1;
    step(1);
    chk(16'h2400, 16'h2400);
    events.runDone = 1'b0;
    events.targetArrive = 1'b0;
    events.runStart = 1'b1;
    #1;
    chkMv(1'b0);
    step(1);
    events.runStart = 1'b0;
    events.errorActive = 1'b1;
    events.overcurrent = 1'b1;
    step(1);
    chk(16'h4488, 16'h4488);
    chkSt(DSW_FAULT);
    events.errorActive = 1'b0;
    events.overcurrent = 1'b0;
    step(1);
    chk(16'h0088, 16'h0088);
    plc_u.ackFault();
    step(2);
    chk(16'h44c8, 16'h0440);
    chkSt(DSW_INHIBIT);
    plc_u.setCw(16'h0408);
    step(2);
    chk(16'h0040, 16'h0000);
    chk(16'h1402, 16'h0000);
    chkSt(DSW_RDY_SWON);
    plc_u.setCw(16'h0000);
    step(1);
    chk(16'h0007, 16'h0000);
    chkSt(DSW_NOT_READY);
    tally_and_finish();
  end
endmodule
